/* bank_map.vh */
// Constants for the external bus chip select controller
`ifndef BANK_MAP_VH
`define BANK_MAP_VH
`define NUM_BANKS 6
`define CFG_EN_BIT 0
`define CFG_WIDTH16_BIT 1
`define CFG_STROBE_BIT 2
`define CFG_SIZE_LSB 4
`define CFG_SIZE_MSB 6
`define TMG_WAIT_LSB 0
`define TMG_WAIT_MSB 3
`define BASE_SHIFT 20
`define BANK_SPAN_BITS 20
`define SPAN_MIN_BITS 16
`define CFG_SIZE_MAX 3'h4
`define MIF_CLK_EN_BIT 0
`define CFG_RESET 8'h00
`define TMG_RESET 8'h0F
`define BASE_RESET 8'h00
`define MIF_CFG_RESET 8'h01
`endif

/* bank_decode.v */
// Address range decoder for one bank
`timescale 1ns/10ps
`include "bank_map.vh"
module bank_decode #(
  parameter AW = 24
) (
  input wire [AW-1:0] addr,
  input wire [7:0] cfg,
  input wire [7:0] base,
  output wire hit
);
  wire [AW-1:0] base_addr;
  wire [AW-1:0] span_mask;
  wire [AW-1:0] min_span;
  wire [2:0] size_code;
  // Base in 1 MB units, size from 64 kB up to 1 MB
  assign size_code = cfg[`CFG_SIZE_MSB:`CFG_SIZE_LSB];
  assign base_addr = {base[AW-`BASE_SHIFT-1:0], {`BASE_SHIFT{1'b0}}};
  assign min_span = {{(AW-`SPAN_MIN_BITS){1'b0}}, {`SPAN_MIN_BITS{1'b1}}};
  assign span_mask = (min_span << size_code) | min_span;
  // Hit only while enabled and inside the programmed range
  assign hit = cfg[`CFG_EN_BIT] &&
    ((addr & ~span_mask) == (base_addr & ~span_mask)) &&
    (size_code <= `CFG_SIZE_MAX);
endmodule

/* bus_cs_ctrl.v */
// External bus chip select controller with word-wide reads
`timescale 1ns/10ps
// How it works
// - Six active-low chip selects, one per bank register set.
// - Each bank has its own enable, range, access time, strobe style, width.
// - Each bank covers up to 1 MB of address space.
// - Per bank choose separate read/write strobes or direction plus data strobe.
// - Every external read fetches a full 16-bit word.
// - Byte reads return the addressed byte and drop the other.
// - An 8-bit bank reads a word as two consecutive byte cycles.
// - A 16-bit bank completes a byte read in one word cycle.
// - Clock output is the system clock, aligned with bus outputs.
// - Clock output driven after reset; software may float it.
// - Each bank has config, base address and timing registers.
// - Clock output enable is a bit of the memory interface config.
`include "bank_map.vh"
module bus_cs_ctrl #(
  parameter AW = 24
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire core_system_clock,
  input wire cfg_we,
  input wire [2:0] cfg_bank,
  input wire [1:0] cfg_sel,
  input wire [7:0] cfg_wdata,
  input wire req_valid,
  input wire req_write,
  input wire req_byte,
  input wire [AW-1:0] req_addr,
  input wire [15:0] req_wdata,
  output wire req_ready,
  output reg resp_valid,
  output reg [15:0] resp_rdata,
  output reg req_miss,
  output reg [AW-1:0] ext_addr,
  output reg [15:0] ext_dout,
  output reg ext_dout_en,
  input wire [15:0] ext_din,
  output reg [`NUM_BANKS-1:0] bank_select_n,
  output reg rd_n,
  output reg wr_n,
  output reg rw_dir,
  output reg ds_n,
  output wire bus_clock_out,
  output wire bus_clock_out_en,
  output reg [7:0] memory_interface_config,
  output wire bus_busy
);
  localparam S_IDLE = 3'b001;
  localparam S_ACC = 3'b010;
  localparam S_DONE = 3'b100;
  localparam SEL_CFG = 2'h0;
  localparam SEL_BASE = 2'h1;
  localparam SEL_TMG = 2'h2;
  localparam SEL_MIF = 2'h3;
  reg [7:0] bank_config [0:`NUM_BANKS-1];
  reg [7:0] bank_base [0:`NUM_BANKS-1];
  reg [7:0] bank_timing [0:`NUM_BANKS-1];
  reg [2:0] state_reg;
  reg [2:0] cur_bank_reg;
  reg [3:0] wait_reg;
  reg half_reg;
  reg write_reg;
  reg byte_reg;
  reg [AW-1:0] addr_reg;
  reg [15:0] wdata_reg;
  reg [7:0] low_byte_reg;
  wire [`NUM_BANKS-1:0] hits;
  reg [2:0] hit_idx;
  reg hit_any;
  integer k;
  integer j;
  genvar g;
  // Per-bank range decoders
  generate
    for (g = 0; g < `NUM_BANKS; g = g + 1) begin : g_dec
      bank_decode #(.AW(AW)) u_dec (
        .addr(req_addr),
        .cfg(bank_config[g]),
        .base(bank_base[g]),
        .hit(hits[g])
      );
    end
  endgenerate
  // Lowest matching bank wins so only one select can assert
  always @* begin
    hit_idx = 3'h0;
    hit_any = 1'b0;
    for (k = `NUM_BANKS - 1; k >= 0; k = k - 1) begin
      if (hits[k]) begin
        hit_idx = k[2:0];
        hit_any = 1'b1;
      end
    end
  end
  // Bank field helpers
  function is_wide;
    input [7:0] c;
    begin
      is_wide = c[`CFG_WIDTH16_BIT];
    end
  endfunction
  function is_ds_style;
    input [7:0] c;
    begin
      is_ds_style = c[`CFG_STROBE_BIT];
    end
  endfunction
  wire [7:0] cur_cfg = bank_config[cur_bank_reg];
  wire [3:0] cur_wait = bank_timing[cur_bank_reg][`TMG_WAIT_MSB:`TMG_WAIT_LSB];
  wire narrow = !is_wide(cur_cfg);
  assign req_ready = (state_reg == S_IDLE);
  assign bus_busy = (state_reg != S_IDLE);
  // Clock output follows the system clock, enabled by config bit
  assign bus_clock_out = core_system_clock;
  assign bus_clock_out_en = memory_interface_config[`MIF_CLK_EN_BIT];
  // Bank register file writes
  always @(posedge clk) begin
    if (!rst_n) begin
      for (j = 0; j < `NUM_BANKS; j = j + 1) begin
        bank_config[j] <= `CFG_RESET;
        bank_base[j] <= `BASE_RESET;
        bank_timing[j] <= `TMG_RESET;
      end
      memory_interface_config <= `MIF_CFG_RESET;
    end else if (ce && cfg_we) begin
      if (cfg_sel == SEL_MIF) begin
        memory_interface_config <= cfg_wdata;
      end else if (cfg_bank < `NUM_BANKS) begin
        case (cfg_sel)
          SEL_CFG: bank_config[cfg_bank] <= cfg_wdata;
          SEL_BASE: bank_base[cfg_bank] <= cfg_wdata;
          SEL_TMG: bank_timing[cfg_bank] <= cfg_wdata;
          default: bank_config[cfg_bank] <= bank_config[cfg_bank];
        endcase
      end
    end
  end
  // Bus cycle sequencer
  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      cur_bank_reg <= 3'h0;
      wait_reg <= 4'h0;
      half_reg <= 1'b0;
      write_reg <= 1'b0;
      byte_reg <= 1'b0;
      addr_reg <= {AW{1'b0}};
      wdata_reg <= 16'h0000;
      low_byte_reg <= 8'h00;
      resp_valid <= 1'b0;
      resp_rdata <= 16'h0000;
      req_miss <= 1'b0;
      ext_addr <= {AW{1'b0}};
      ext_dout <= 16'h0000;
      ext_dout_en <= 1'b0;
      bank_select_n <= {`NUM_BANKS{1'b1}};
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      rw_dir <= 1'b1;
      ds_n <= 1'b1;
    end else if (ce) begin
      resp_valid <= 1'b0;
      req_miss <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (req_valid) begin
            if (!hit_any) begin
              req_miss <= 1'b1;
              resp_valid <= 1'b1;
            end else begin
              cur_bank_reg <= hit_idx;
              write_reg <= req_write;
              byte_reg <= req_byte;
              addr_reg <= req_addr;
              wdata_reg <= req_wdata;
              half_reg <= 1'b0;
              wait_reg <= bank_timing[hit_idx][`TMG_WAIT_MSB:`TMG_WAIT_LSB];
              // Reads always start word aligned
              ext_addr <= req_write ? req_addr : {req_addr[AW-1:1], 1'b0};
              ext_dout <= req_wdata;
              ext_dout_en <= req_write;
              bank_select_n <= ~({{(`NUM_BANKS-1){1'b0}}, 1'b1} << hit_idx);
              if (is_ds_style(bank_config[hit_idx])) begin
                rw_dir <= ~req_write;
                ds_n <= 1'b0;
              end else begin
                rd_n <= req_write;
                wr_n <= ~req_write;
              end
              state_reg <= S_ACC;
            end
          end
        end
        S_ACC: begin
          if (wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
          end else if (!write_reg && narrow && !half_reg) begin
            // Second byte cycle on a narrow bank
            low_byte_reg <= ext_din[7:0];
            half_reg <= 1'b1;
            ext_addr <= {addr_reg[AW-1:1], 1'b1};
            wait_reg <= cur_wait;
          end else if (write_reg && narrow && !byte_reg && !half_reg) begin
            half_reg <= 1'b1;
            ext_addr <= {addr_reg[AW-1:1], 1'b1};
            ext_dout <= {8'h00, wdata_reg[15:8]};
            wait_reg <= cur_wait;
          end else begin
            if (!write_reg) begin
              // Assemble word then pick byte when asked
              if (byte_reg) begin
                if (narrow) begin
                  resp_rdata <= {8'h00, addr_reg[0] ? ext_din[7:0] : low_byte_reg};
                end else begin
                  resp_rdata <= {8'h00, addr_reg[0] ? ext_din[15:8] : ext_din[7:0]};
                end
              end else begin
                resp_rdata <= narrow ? {ext_din[7:0], low_byte_reg} : ext_din;
              end
            end
            resp_valid <= 1'b1;
            bank_select_n <= {`NUM_BANKS{1'b1}};
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            ds_n <= 1'b1;
            rw_dir <= 1'b1;
            ext_dout_en <= 1'b0;
            state_reg <= S_DONE;
          end
        end
        S_DONE: begin
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule

/* bus_cs_ctrl_asserts.sv */
// Concurrent checks on the chip select controller ports
`timescale 1ns/10ps
`include "bank_map.vh"
module bus_cs_ctrl_asserts (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire req_valid,
  input wire req_ready,
  input wire resp_valid,
  input wire req_miss,
  input wire ext_dout_en,
  input wire [`NUM_BANKS-1:0] bank_select_n,
  input wire rd_n,
  input wire wr_n,
  input wire rw_dir,
  input wire ds_n,
  input wire core_system_clock,
  input wire bus_clock_out,
  input wire bus_clock_out_en,
  input wire [7:0] memory_interface_config
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Select, strobe and clock relations
  chk_one_sel: assert property ($onehot0(~bank_select_n)) else $error("two selects");
  chk_clk_copy: assert property (bus_clock_out == core_system_clock) else $error("clk");
  chk_clk_en: assert property (bus_clock_out_en == memory_interface_config[0])
    else $error("clk en");
  chk_rst_clk: assert property ($rose(rst_n) |-> bus_clock_out_en) else $error("rst");
  chk_miss_idle: assert property (req_miss |-> resp_valid && &bank_select_n)
    else $error("miss");
  chk_take_sel: assert property (
    ce && req_valid && req_ready |=> req_miss || !(&bank_select_n)) else $error("take");
  chk_strobe_sel: assert property (!rd_n || !ds_n |-> !(&bank_select_n))
    else $error("strobe");
  chk_rd_nodrv: assert property (!rd_n || (!ds_n && rw_dir) |-> !ext_dout_en)
    else $error("rd drive");
  chk_wr_drv: assert property (!wr_n || (!ds_n && !rw_dir) |-> ext_dout_en)
    else $error("wr drive");
  chk_one_style: assert property (!(!rd_n && !ds_n)) else $error("style");
  cover property (resp_valid && !req_miss);
  cover property (req_miss);
  cover property (!ds_n && rw_dir);
endmodule
bind bus_cs_ctrl bus_cs_ctrl_asserts i_bus_cs_ctrl_asserts (.clk(clk), .rst_n(rst_n), .ce(ce),
  .req_valid(req_valid), .req_ready(req_ready), .resp_valid(resp_valid), .req_miss(req_miss),
  .ext_dout_en(ext_dout_en), .bank_select_n(bank_select_n), .rd_n(rd_n), .wr_n(wr_n),
  .rw_dir(rw_dir), .ds_n(ds_n), .core_system_clock(core_system_clock),
  .bus_clock_out(bus_clock_out), .bus_clock_out_en(bus_clock_out_en),
  .memory_interface_config(memory_interface_config));

/* ext_mem_model.sv */
// Behavioural external memory behind the chip selects
`timescale 1ns/10ps
module ext_mem_model (
  input wire clk,
  input wire [5:0] bank_select_n,
  input wire [23:0] ext_addr,
  input wire [15:0] ext_dout,
  input wire rd_n,
  input wire wr_n,
  input wire rw_dir,
  input wire ds_n,
  output wire [15:0] ext_din
);
  reg [15:0] mem [0:15];
  reg [15:0] last_reg;
  integer i;
  wire [15:0] word = mem[ext_addr[4:1]];
  wire sel = ~&bank_select_n;
  wire rd = sel && (!rd_n || (rw_dir && !ds_n));
  wire wr = sel && (!wr_n || (!rw_dir && !ds_n));
  // Addressed byte on the low lane; inverse of last value when released
  assign ext_din = rd ? {word[15:8], ext_addr[0] ? word[15:8] : word[7:0]} : ~last_reg;
  initial begin
    for (i = 0; i < 16; i = i + 1) mem[i] = 16'hA050 + i * 16'h0101;
    last_reg = 16'h0000;
  end
  // Word writes at even addresses, read history
  always @(posedge clk) begin
    if (rd) last_reg <= ext_din;
    if (wr && !ext_addr[0]) mem[ext_addr[4:1]] <= ext_dout;
  end
endmodule

/* external_bus_chip_select_controller_test.sv */
// Self-checking bench for the chip select controller
`timescale 1ns/10ps
module external_bus_chip_select_controller_test;
  reg clk = 0, rst_n = 0, cfg_we = 0, req_valid = 0, req_write = 0, req_byte = 0;
  reg ce = 1;
  reg [2:0] cfg_bank = 3'h0;
  reg [1:0] cfg_sel = 2'h0;
  reg [7:0] cfg_wdata = 8'h00;
  reg [23:0] req_addr = 24'h000000;
  reg [15:0] req_wdata = 16'h0000;
  wire [15:0] ext_din, ext_dout, resp_rdata;
  wire [23:0] ext_addr;
  wire [5:0] bank_select_n;
  wire [7:0] memory_interface_config;
  wire req_ready, resp_valid, req_miss, ext_dout_en, rd_n, wr_n, rw_dir, ds_n;
  wire bus_clock_out, bus_clock_out_en, bus_busy;
  integer err_count = 0, cmp_count = 0, lows, n;
  reg [15:0] rdat;
  reg [5:0] sel;
  reg miss, odd, dsl;
  always #5 clk = ~clk;
  bus_cs_ctrl i_bus_cs_ctrl (.clk, .rst_n, .ce, .core_system_clock(clk), .cfg_we,
    .cfg_bank, .cfg_sel, .cfg_wdata, .req_valid, .req_write, .req_byte, .req_addr, .req_wdata,
    .req_ready, .resp_valid, .resp_rdata, .req_miss, .ext_addr, .ext_dout, .ext_dout_en,
    .ext_din, .bank_select_n, .rd_n, .wr_n, .rw_dir, .ds_n, .bus_clock_out,
    .bus_clock_out_en, .memory_interface_config, .bus_busy);
  ext_mem_model i_ext_mem_model (.clk, .bank_select_n, .ext_addr, .ext_dout, .rd_n, .wr_n,
    .rw_dir, .ds_n, .ext_din);
  task chk(input [23:0] s, input [23:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        err_count = err_count + 1;
        $display("ERROR %0t saw %h expected %h", $time, s, e);
      end
    end
  endtask
  task cfg(input [1:0] s, input [2:0] b, input [7:0] d);
    begin
      @(posedge clk);
      cfg_we <= 1;
      cfg_sel <= s;
      cfg_bank <= b;
      cfg_wdata <= d;
      @(posedge clk);
      cfg_we <= 0;
    end
  endtask
  task acc(input w, input b, input [23:0] a, input [15:0] d);
    begin
      @(posedge clk);
      {req_valid, req_write, req_byte, req_addr, req_wdata} <= {1'b1, w, b, a, d};
      @(posedge clk);
      req_valid <= 0;
      {lows, odd, dsl, sel, miss, n} = 0;
      while (n < 100) begin
        #1;
        n = n + 1;
        if (bank_select_n !== 6'h3F) begin
          lows = lows + 1;
          sel = bank_select_n;
          odd = odd | ext_addr[0];
          dsl = dsl | !ds_n;
        end
        if (resp_valid === 1'b1) begin
          {rdat, miss, n} = {resp_rdata, req_miss, 32'd200};
        end
        if (n < 100) @(posedge clk);
      end
      chk(n, 200);
    end
  endtask
  task t_reset;
    begin
      chk(bank_select_n, 6'h3F);
      chk(bus_clock_out_en, 1);
      chk(memory_interface_config, 8'h01);
    end
  endtask
  task t_wide;
    begin
      cfg(0, 0, 8'h43);
      cfg(1, 0, 8'h01);
      cfg(2, 0, 8'h00);
      acc(1, 0, 24'h100002, 16'hBEEF);
      chk(sel, 6'h3E);
      chk({req_ready, bus_busy}, 2'b01);
      acc(0, 0, 24'h100002, 0);
      chk(rdat, 16'hBEEF);
      chk(lows, 1);
      acc(0, 1, 24'h100003, 0);
      chk(rdat, 16'h00BE);
      chk(odd, 0);
      chk(lows, 1);
      chk(dsl, 0);
      acc(0, 1, 24'h1FFFFE, 0);
      chk({miss, rdat}, 17'h0005F);
      cfg(2, 0, 8'h03);
      acc(0, 0, 24'h100004, 0);
      chk(lows, 4);
      chk(rdat, 16'hA252);
    end
  endtask
  task t_narrow;
    begin
      cfg(0, 5, 8'h45);
      cfg(1, 5, 8'h02);
      cfg(2, 5, 8'h01);
      acc(0, 1, 24'h200006, 0);
      chk(rdat, 16'h0053);
      chk(odd, 1);
      chk({sel, dsl}, 7'h3F);
      chk(lows, 4);
      acc(0, 0, 24'h200006, 0);
      chk(rdat, 16'hA353);
      chk(lows, 4);
    end
  endtask
  task t_miss;
    begin
      acc(0, 0, 24'h400000, 0);
      chk(miss, 1);
      cfg(0, 5, 8'h00);
      acc(0, 0, 24'h200000, 0);
      chk(miss, 1);
      chk(lows, 0);
    end
  endtask
  task t_clk;
    begin
      cfg(3, 0, 8'h00);
      @(posedge clk);
      #1;
      chk({bus_clock_out_en, bus_clock_out}, 2'b01);
      cfg(3, 0, 8'h01);
      @(posedge clk);
      #1;
      chk(bus_clock_out_en, 1);
    end
  endtask
  task t_ce;
    begin
      @(posedge clk);
      ce <= 0;
      {cfg_we, cfg_sel, cfg_wdata} <= {1'b1, 2'h3, 8'h00};
      {req_valid, req_write, req_byte, req_addr} <= {1'b1, 1'b0, 1'b0, 24'h100000};
      repeat (3) @(posedge clk);
      {ce, cfg_we, req_valid} <= 3'b100;
      #1;
      chk(bank_select_n, 6'h3F);
      chk({resp_valid, req_ready, bus_busy}, 3'b010);
      chk(memory_interface_config, 8'h01);
      acc(0, 0, 24'h100002, 0);
      chk(rdat, 16'hBEEF);
    end
  endtask
  task end_sim;
    begin
      $display("errors %0d compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    #1;
    t_reset;
    t_wide;
    t_narrow;
    t_miss;
    t_clk;
    t_ce;
    end_sim;
  end
  initial begin
    #100000;
    err_count = err_count + 1;
    end_sim;
  end
endmodule
